/* File: ldc_io_clocks.sv */
// Operation
// - Compressed bitstream arrives one bit per receive clock on the data pin.
// - Receive sampling edge is selectable, rising or falling.
// - Bits arriving while bit enable is low are dropped.
// - A phase accumulator on the system clock stands in for the oscillator and paces the PCM clocks; a programmable system clock divider makes the core clock.
// - Core clock rate is adjustable to save power.
// - Bit clock, word clock and oversampling clock are generated.
// - Output sample rate is trimmable in steps of about 0.024 ppm at 48 kHz to 0.15 ppm at 8 kHz with the default TRIM_STEP.
// - Rate trimming runs autonomously without host action.
// - Samples per frame are compared with the nominal count.
// - The fraction value moves in small steps on an update strobe.
// - Samples leave as serial data with bit clock and word clock.
// - Word length selects 16, 18, 20 or 24 bits.
// - A flag selects MSB-first or LSB-first output.
// - Supported rates are 48, 32, 24, 16, 12 and 8 kHz.
`timescale 1ns/1ps
module ldc_io_clocks #(
  parameter int unsigned   FIFO_DEPTH   = 8,
  parameter int unsigned   FRAME_CYCLES = ldc_pkg::FRAME_CYCLES,
  parameter logic [15:0]   TRIM_STEP    = ldc_pkg::TRIM_STEP
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            bitstream_in_data_i,
  input  wire logic                            bitstream_in_clock_i,
  input  wire logic                            bit_enable_i,
  input  wire logic                            sample_falling_edge_i,
  output logic [7:0]                           stream_byte_o,
  output logic                                 stream_byte_valid_o,
  input  wire logic                            stream_byte_ready_i,
  input  wire logic                            rate_trim_pulse_i,
  input  wire logic [3:0]                      core_clock_div_i,
  output logic                                 core_clock_enable_o,
  input  wire ldc_pkg::ldc_pcm_format_config_t pcm_format_config_i,
  input  wire ldc_pkg::ldc_sample_t            sample_i,
  input  wire logic                            sample_valid_i,
  output logic                                 sample_ready_o,
  output logic                                 pcm_out_data_o,
  output logic                                 pcm_bit_clock_o,
  output logic                                 pcm_word_clock_o,
  output logic                                 dac_oversample_clock_o,
  output logic [ldc_pkg::TRIM_W-1:0]           pll_fraction_value_o,
  output logic                                 stream_overrun_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                      sck_d;
    logic [7:0]                shift;
    logic [2:0]                nbit;
    logic [7:0]                byte_q;
    logic                      byte_v;
    logic                      overrun;
    logic [ldc_pkg::NCO_W-1:0] nco;
    logic                      bit_tick;
    logic [3:0]                core_cnt;
    logic                      core_en;
    logic [2:0]                ovs_cnt;
    logic                      ovs;
    logic                      trim_d;
    logic                      seen_frame;
    logic [31:0]               frame_cnt;
    logic [15:0]               smp_cnt;
    logic [15:0]               frac;
    logic                      update;
  } ldc_state_t;

  ldc_state_t st;
  ldc_state_t next_st;

  logic                          fifo_in_ready;
  logic [7:0]                    fifo_out_data;
  logic                          fifo_out_valid;
  logic                          tx_ready;
  logic                          tx_bclk;
  logic                          tx_wclk;
  logic                          tx_data;
  logic                          sck_edge;
  logic [15:0]                   expect_cnt;
  logic [ldc_pkg::NCO_W-1:0]     nco_inc;

  // Nominal bit-clock tick rate: two ticks per bit, 64 bits per sample.
  function automatic logic [ldc_pkg::NCO_W-1:0] base_inc(input logic [2:0] sel);
    logic [63:0] num;
    num = 64'(ldc_pkg::rate_hz(sel)) * 64'(2 * 2 * ldc_pkg::BCLK_PER_WORD) * 64'h1_0000_0000;
    base_inc = ldc_pkg::NCO_W'(num / 64'(ldc_pkg::CLK_HZ));
  endfunction

  // Samples expected in one frame at the nominal rate.
  function automatic logic [15:0] frame_samples(input logic [2:0] sel);
    frame_samples = 16'((32'(ldc_pkg::rate_hz(sel)) * ldc_pkg::FRAME_MS) / 1000);
  endfunction

  assign sck_edge   = sample_falling_edge_i ? (st.sck_d && !bitstream_in_clock_i)
                                            : (!st.sck_d && bitstream_in_clock_i);
  assign expect_cnt = frame_samples(pcm_format_config_i.rate_sel);
  // Fraction is signed about mid-scale; each LSB shifts the rate about 0.0015 ppm at 48 kHz, 0.009 ppm at 8 kHz.
  assign nco_inc    = base_inc(pcm_format_config_i.rate_sel)
                      + ldc_pkg::NCO_W'(st.frac) - ldc_pkg::NCO_W'(16'h8000);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sck_d = bitstream_in_clock_i;
    if (st.byte_v && fifo_in_ready) begin
      next_st.byte_v = 1'b0;
    end
    if (sck_edge && bit_enable_i) begin
      next_st.shift = {st.shift[6:0], bitstream_in_data_i};
      next_st.nbit  = st.nbit + 3'h1;
      if (st.nbit == 3'h7) begin
        next_st.byte_q = {st.shift[6:0], bitstream_in_data_i};
        next_st.byte_v = 1'b1;
        if (st.byte_v && !fifo_in_ready) begin
          next_st.overrun = 1'b1;
        end
      end
    end

    // Oscillator stand-in: phase accumulator clocked by the system clock.
    {next_st.bit_tick, next_st.nco} = {1'b0, st.nco} + {1'b0, nco_inc};

    next_st.core_en  = 1'b0;
    next_st.core_cnt = st.core_cnt + 4'h1;
    if (st.core_cnt >= core_clock_div_i) begin
      next_st.core_cnt = 4'h0;
      next_st.core_en  = 1'b1;
    end

    if (st.bit_tick) begin
      next_st.ovs_cnt = st.ovs_cnt + 3'h1;
      if (st.ovs_cnt[1:0] == 2'h3) begin
        next_st.ovs = !st.ovs;
      end
    end

    // Frame-based rate control, no host involvement.
    next_st.trim_d = rate_trim_pulse_i;
    next_st.update = 1'b0;
    if (st.frame_cnt != 32'hffff_ffff) begin
      next_st.frame_cnt = st.frame_cnt + 32'h1;
    end
    if (tx_ready) begin
      next_st.smp_cnt = st.smp_cnt + 16'h1;
    end
    if (rate_trim_pulse_i && !st.trim_d) begin
      next_st.frame_cnt  = 32'h0;
      next_st.smp_cnt    = 16'h0;
      next_st.seen_frame = 1'b1;
      if (st.seen_frame) begin
        next_st.update = 1'b1;
        // Saturate: a step that would wrap the trim value is skipped.
        if (st.smp_cnt < expect_cnt && st.frac <= 16'hffff - TRIM_STEP) begin
          next_st.frac = st.frac + TRIM_STEP;
        end else if (st.smp_cnt > expect_cnt && st.frac >= TRIM_STEP) begin
          next_st.frac = st.frac - TRIM_STEP;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st      <= '0;
      st.frac <= 16'h8000;
      // Start from the pin's level so a clock held high at release is no edge.
      st.sck_d <= bitstream_in_clock_i;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  ldc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (st.byte_q),
    .in_valid_i  (st.byte_v),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (stream_byte_ready_i && !stream_byte_valid_o)
  );

  ldc_pcm_tx u_tx (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .bit_tick_i     (st.bit_tick),
    .cfg_i          (pcm_format_config_i),
    .sample_i       (sample_i),
    .sample_valid_i (sample_valid_i),
    .sample_ready_o (tx_ready),
    .bclk_o         (tx_bclk),
    .wclk_o         (tx_wclk),
    .data_o         (tx_data)
  );

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stream_byte_o          <= 8'h00;
      stream_byte_valid_o    <= 1'b0;
      sample_ready_o         <= 1'b0;
      pcm_out_data_o         <= 1'b0;
      pcm_bit_clock_o        <= 1'b0;
      pcm_word_clock_o       <= 1'b0;
      dac_oversample_clock_o <= 1'b0;
      pll_fraction_value_o   <= 16'h8000;
      core_clock_enable_o    <= 1'b0;
      stream_overrun_o       <= 1'b0;
    end else begin
      if (stream_byte_valid_o && stream_byte_ready_i) begin
        stream_byte_valid_o <= 1'b0;
      end else if (!stream_byte_valid_o && fifo_out_valid && stream_byte_ready_i) begin
        stream_byte_o       <= fifo_out_data;
        stream_byte_valid_o <= 1'b1;
      end
      sample_ready_o         <= tx_ready;
      pcm_out_data_o         <= tx_data;
      pcm_bit_clock_o        <= tx_bclk;
      pcm_word_clock_o       <= tx_wclk;
      dac_oversample_clock_o <= st.ovs;
      pll_fraction_value_o   <= st.frac;
      core_clock_enable_o    <= st.core_en;
      stream_overrun_o       <= st.overrun;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_drop_disabled;
    @(posedge clk_i) disable iff (reset_i)
      (!bit_enable_i) |=> (st.nbit == $past(st.nbit));
  endproperty
  a_drop_disabled: assert property (p_drop_disabled) else $error("bit taken while disabled");

  property p_take_enabled;
    @(posedge clk_i) disable iff (reset_i)
      (bit_enable_i && sck_edge) |=> (st.shift[0] == $past(bitstream_in_data_i));
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("enabled bit not shifted in");

  property p_edge_select;
    @(posedge clk_i) disable iff (reset_i)
      (sck_edge && sample_falling_edge_i) |-> !bitstream_in_clock_i && $past(bitstream_in_clock_i);
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("wrong sampling edge");

  property p_msb_first;
    @(posedge clk_i) disable iff (reset_i)
      (bit_enable_i && sck_edge && st.nbit == 3'h7) |=> (st.byte_q[7:1] == $past(st.shift[6:0]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("byte not assembled msb first");

  property p_trim_step;
    @(posedge clk_i) disable iff (reset_i)
      (st.frac != $past(st.frac)) |-> $past(rate_trim_pulse_i && !st.trim_d && st.seen_frame);
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("fraction moved without frame pulse");

  property p_trim_dir;
    @(posedge clk_i) disable iff (reset_i)
      (rate_trim_pulse_i && !st.trim_d && st.seen_frame && st.smp_cnt < expect_cnt
       && st.frac <= 16'hffff - TRIM_STEP) |=> (st.frac == $past(st.frac) + TRIM_STEP);
  endproperty
  a_trim_dir: assert property (p_trim_dir) else $error("slow output not sped up");

  property p_update_strobe;
    @(posedge clk_i) disable iff (reset_i)
      st.update |=> !st.update;
  endproperty
  a_update_strobe: assert property (p_update_strobe) else $error("update strobe too long");

  property p_word_clock_steady;
    @(posedge clk_i) disable iff (reset_i)
      $changed(pcm_word_clock_o) |-> $past(pcm_bit_clock_o, 1) == 1'b1 && $past(st.bit_tick, 2);
  endproperty
  a_word_clock_steady: assert property (p_word_clock_steady) else $error("word clock changed mid word");

  property p_core_enable;
    @(posedge clk_i) disable iff (reset_i)
      st.core_en |-> (st.core_cnt == 4'h0);
  endproperty
  a_core_enable: assert property (p_core_enable) else $error("core enable off cadence");

  property p_core_gap;
    @(posedge clk_i) disable iff (reset_i)
      (st.core_en && core_clock_div_i != 4'h0) |=> !st.core_en;
  endproperty
  a_core_gap: assert property (p_core_gap) else $error("core enable back to back");

  property p_data_on_rise;
    @(posedge clk_i) disable iff (reset_i)
      $changed(pcm_out_data_o) |-> $rose(pcm_bit_clock_o);
  endproperty
  a_data_on_rise: assert property (p_data_on_rise) else $error("pcm data moved off rising bit clock");

  property p_bit_clock_pace;
    @(posedge clk_i) disable iff (reset_i)
      $changed(pcm_bit_clock_o) |-> $past(st.bit_tick, 2);
  endproperty
  a_bit_clock_pace: assert property (p_bit_clock_pace) else $error("bit clock moved without tick");

  property p_load_at_word_start;
    @(posedge clk_i) disable iff (reset_i)
      sample_ready_o |-> pcm_word_clock_o ##1 !pcm_word_clock_o;
  endproperty
  a_load_at_word_start: assert property (p_load_at_word_start) else $error("sample taken mid period");

  property p_overrun_sticky;
    @(posedge clk_i) disable iff (reset_i)
      stream_overrun_o |=> stream_overrun_o;
  endproperty
  a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun flag cleared");

  property p_frac_out;
    @(posedge clk_i) disable iff (reset_i)
      pll_fraction_value_o == $past(st.frac);
  endproperty
  a_frac_out: assert property (p_frac_out) else $error("fraction output lags trim value");

  c_byte_out: cover property (@(posedge clk_i) stream_byte_valid_o && stream_byte_ready_i);
  c_trim_up: cover property (@(posedge clk_i) st.update && st.frac > 16'h8000);
  c_word_flip: cover property (@(posedge clk_i) $rose(pcm_word_clock_o));
  c_overrun: cover property (@(posedge clk_i) $rose(st.overrun));

endmodule // ldc_io_clocks

/* File: ldc_pkg.sv */
package ldc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned REF_HZ        = 14_720_000;
  localparam int unsigned FRAME_MS      = 432;
  localparam int unsigned FRAME_CYCLES  = (CLK_HZ / 1000) * FRAME_MS;
  localparam int unsigned NCO_W         = 32;
  localparam int unsigned TRIM_W        = 16;
  localparam logic [15:0] TRIM_STEP     = 16'h0010;

  // ----------------------------------------------------------------------
  // Sample rates and PCM format
  // ----------------------------------------------------------------------
  localparam int unsigned BCLK_PER_WORD = 32;
  localparam int unsigned SAMPLE_W      = 24;
  localparam logic [1:0]  WL_16 = 2'h0;
  localparam logic [1:0]  WL_18 = 2'h1;
  localparam logic [1:0]  WL_20 = 2'h2;
  localparam logic [1:0]  WL_24 = 2'h3;
  localparam logic [2:0]  FS_48 = 3'h0;
  localparam logic [2:0]  FS_32 = 3'h1;
  localparam logic [2:0]  FS_24 = 3'h2;
  localparam logic [2:0]  FS_16 = 3'h3;
  localparam logic [2:0]  FS_12 = 3'h4;
  localparam logic [2:0]  FS_8  = 3'h5;
  localparam logic [2:0]  OVS_DIV_LOG2 = 3'h2;

  typedef struct packed {
    logic [1:0] word_len;
    logic       lsb_first;
    logic [2:0] rate_sel;
  } ldc_pcm_format_config_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } ldc_sample_t;

  // Sample rate in Hz for a rate select code.
  function automatic logic [15:0] rate_hz(input logic [2:0] sel);
    unique case (sel)
      FS_48:   rate_hz = 16'hbb80;
      FS_32:   rate_hz = 16'h7d00;
      FS_24:   rate_hz = 16'h5dc0;
      FS_16:   rate_hz = 16'h3e80;
      FS_12:   rate_hz = 16'h2ee0;
      FS_8:    rate_hz = 16'h1f40;
      default: rate_hz = 16'hbb80;
    endcase
  endfunction

  // Number of significant bits for a word length code.
  function automatic logic [4:0] word_bits(input logic [1:0] wl);
    unique case (wl)
      WL_16: word_bits = 5'h10;
      WL_18: word_bits = 5'h12;
      WL_20: word_bits = 5'h14;
      WL_24: word_bits = 5'h18;
    endcase
  endfunction

endpackage

/* File: ldc_fifo.sv */
`timescale 1ns/1ps
module ldc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } ldc_fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  ldc_fifo_state_t  st;
  ldc_fifo_state_t  next_st;
  logic             push;
  logic             pop;

  assign in_ready_o  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = mem[st.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr] <= in_data_i;
    end
  end

  property p_no_overflow;
    @(posedge clk_i) disable iff (reset_i)
      st.cnt <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule // ldc_fifo

/* File: ldc_pcm_tx.sv */
`timescale 1ns/1ps
module ldc_pcm_tx (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            bit_tick_i,
  input  wire ldc_pkg::ldc_pcm_format_config_t cfg_i,
  input  wire ldc_pkg::ldc_sample_t            sample_i,
  input  wire logic                            sample_valid_i,
  output logic                                 sample_ready_o,
  output logic                                 bclk_o,
  output logic                                 wclk_o,
  output logic                                 data_o
);
  typedef struct packed {
    logic                            bclk;
    logic                            wclk;
    logic                            data;
    logic [4:0]                      bitno;
    ldc_pkg::ldc_sample_t            cur;
    ldc_pkg::ldc_pcm_format_config_t fmt;
  } ldc_tx_state_t;

  ldc_tx_state_t st;
  ldc_tx_state_t next_st;
  logic [4:0]    nbits;
  logic [23:0]   word;
  logic          ldbit;

  assign nbits = ldc_pkg::word_bits(st.fmt.word_len);
  assign word  = st.wclk ? st.cur.right : st.cur.left;
  assign sample_ready_o = bit_tick_i && st.bclk && st.wclk && (st.bitno == 5'h1f);
  assign bclk_o = st.bclk;
  assign wclk_o = st.wclk;
  assign data_o = st.data;

  // MSB-first sends bits 23 down; LSB-first starts at the word's low end.
  always_comb begin
    next_st = st;
    ldbit   = 1'b0;
    if (st.bitno < nbits) begin
      ldbit = st.fmt.lsb_first ? word[5'd24 - nbits + st.bitno]
                               : word[5'd23 - st.bitno];
    end
    if (bit_tick_i) begin
      next_st.bclk = !st.bclk;
      if (!st.bclk) begin
        next_st.data = ldbit;
      end else begin
        next_st.bitno = st.bitno + 5'h1;
        if (st.bitno == 5'h1f) begin
          next_st.wclk = !st.wclk;
          if (st.wclk) begin
            next_st.fmt = cfg_i;
            next_st.cur = sample_valid_i ? sample_i : '0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // ldc_pcm_tx

/* File: ldc_dac_model.sv */
`timescale 1ns/1ps
module ldc_dac_model (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        bclk_i,
  input  wire logic        wclk_i,
  input  wire logic        data_i,
  output logic [31:0]      left_o,
  output logic [31:0]      right_o,
  output logic [5:0]       slot_bits_o
);
  // ----------------------------------------------------------------
  // Capture of serial words
  // ----------------------------------------------------------------
  logic        bclk_q;
  logic        wclk_q;
  logic [31:0] shift;
  logic [5:0]  cnt;

  // Bits are taken on the falling bit clock, half a bit after they change.
  always_ff @(posedge clk_i) begin
    bclk_q <= bclk_i;
    wclk_q <= wclk_i;
    if (reset_i) begin
      cnt         <= 6'h00;
      slot_bits_o <= 6'h00;
      shift       <= 32'h0;
    end else begin
      if (bclk_q && !bclk_i) begin
        shift <= {shift[30:0], data_i};
        cnt   <= cnt + 6'h01;
        // The word clock flips with the last bit, so the slot's channel is its old level.
        if (cnt == 6'h1f && wclk_q) begin
          right_o <= {shift[30:0], data_i};
        end else if (cnt == 6'h1f) begin
          left_o <= {shift[30:0], data_i};
        end
      end
      if (wclk_i != wclk_q) begin
        slot_bits_o <= cnt + 6'(bclk_q && !bclk_i);
        cnt         <= 6'h00;
      end
    end
  end
endmodule // ldc_dac_model

/* File: layer3_decoder_io_and_clocks_tb.sv */
`timescale 1ns/1ps
module layer3_decoder_io_and_clocks_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                           clk_i;
  logic                           reset_i;
  logic                           sdata;
  logic                           sclk;
  logic                           ben;
  logic                           sfall;
  logic [7:0]                     sbyte;
  logic                           sbv;
  logic                           sbr;
  logic                           trim;
  logic [3:0]                     div;
  logic                           cen;
  ldc_pkg::ldc_pcm_format_config_t cfg;
  ldc_pkg::ldc_sample_t           smp;
  logic                           svalid;
  logic                           sready;
  logic                           pdata;
  logic                           pbclk;
  logic                           pwclk;
  logic                           povs;
  logic [15:0]                    frac;
  logic                           ovr;
  logic [31:0]                    left;
  logic [31:0]                    right;
  logic [5:0]                     sbits;
  int                             failures;
  int                             samples_checked;
  int                             cyc;
  int                             n_ready;
  int                             t0;
  int                             o0;
  int                             n_ovs;
  logic                           ovs_q;
  int                             hz[6] = '{48000, 32000, 24000, 16000, 12000, 8000};
  logic [7:0]                     rx_q[$];

  ldc_io_clocks #(.FIFO_DEPTH(8), .FRAME_CYCLES(1000), .TRIM_STEP(16'h0040)) u_ldc_io_clocks (
    .clk_i(clk_i), .reset_i(reset_i), .bitstream_in_data_i(sdata), .bitstream_in_clock_i(sclk),
    .bit_enable_i(ben), .sample_falling_edge_i(sfall), .stream_byte_o(sbyte),
    .stream_byte_valid_o(sbv), .stream_byte_ready_i(sbr), .rate_trim_pulse_i(trim),
    .core_clock_div_i(div), .core_clock_enable_o(cen), .pcm_format_config_i(cfg),
    .sample_i(smp), .sample_valid_i(svalid), .sample_ready_o(sready), .pcm_out_data_o(pdata),
    .pcm_bit_clock_o(pbclk), .pcm_word_clock_o(pwclk), .dac_oversample_clock_o(povs),
    .pll_fraction_value_o(frac), .stream_overrun_o(ovr));

  ldc_dac_model u_ldc_dac_model (.clk_i(clk_i), .reset_i(reset_i), .bclk_i(pbclk),
    .wclk_i(pwclk), .data_i(pdata), .left_o(left), .right_o(right), .slot_bits_o(sbits));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (sbv && sbr) rx_q.push_back(sbyte);
    if (sready) n_ready++;
    if (povs && !ovs_q) n_ovs++;
    ovs_q = povs;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // The unused edge sees the inverted bit, so a wrong edge choice shows up.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdata = b[i] ^ sfall;
      tick(2);
      sclk = 1'b1;
      tick(2);
      sdata = b[i] ^ !sfall;
      tick(2);
      sclk = 1'b0;
      tick(2);
    end
  endtask

  task automatic wait_ready;
    int k0;
    k0 = n_ready;
    for (int t = 0; t < 6000 && n_ready == k0; t++) tick(1);
    if (n_ready == k0) begin
      failures++;
      close_out();
    end
  endtask

  function automatic logic [31:0] pcm_word(input logic [23:0] s, input int wl, input logic lsb);
    int          n;
    logic [31:0] w;
    n = 16 + 2 * wl + (wl == 3 ? 2 : 0);
    w = 32'h0;
    for (int i = 0; i < n; i++) w[31-i] = lsb ? s[24-n+i] : s[23-i];
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {sdata, sclk, sfall, trim, svalid} = 5'h00;
    {reset_i, ben, sbr} = 3'h7;
    div = 4'h0;
    cfg = '{word_len: 2'h0, lsb_first: 1'b0, rate_sel: 3'h0};
    smp = '{left: 24'ha5c3f1, right: 24'h1e2d96};
    tick(3);
    reset_i = 1'b0;
    check("fraction reset", frac, 32'h8000);
    for (int k = 0; k < 3; k++) begin
      div = (k == 0) ? 4'h0 : (k == 1) ? 4'h5 : 4'hf;
      tick(20);
      for (int t = 0; t < 40 && !cen; t++) tick(1);
      t0 = cyc;
      tick(1);
      for (int t = 0; t < 40 && !cen; t++) tick(1);
      check("core enable period", cyc - t0, div + 1);
    end
    ben = 1'b0;
    send_byte(8'h3c);
    ben = 1'b1;
    send_byte(8'ha5);
    sfall = 1'b1;
    send_byte(8'h01);
    tick(10);
    check("bytes kept", rx_q.size(), 2);
    check("rising edge byte", rx_q[0], 8'ha5);
    check("falling edge byte", rx_q[1], 8'h01);
    svalid = 1'b1;
    for (int f = 0; f < 8; f++) begin
      cfg = '{word_len: f[2:1], lsb_first: f[0], rate_sel: 3'h0};
      repeat (3) wait_ready();
      tick(30);
      check("left word", left, pcm_word(smp.left, f[2:1], f[0]));
      check("right word", right, pcm_word(smp.right, f[2:1], f[0]));
      check("bits per slot", sbits, 32);
    end
    for (int r = 0; r < 6; r++) begin
      cfg.rate_sel = r[2:0];
      wait_ready();
      t0 = cyc;
      o0 = n_ovs;
      wait_ready();
      check("sample period", ((cyc - t0) * hz[r] + 200000) / 400000, 100);
      check("oversample periods per sample", n_ovs - o0, 16);
    end
    for (int p = 0; p < 3; p++) begin
      trim = 1'b1;
      tick(1);
      trim = 1'b0;
      tick(4);
      check("fraction step", frac, 32'h8000 + 32'h40 * p);
    end
    sbr = 1'b0;
    rx_q.delete();
    check("no overrun", ovr, 0);
    for (int b = 0; b < 11; b++) send_byte(8'h10 + b[7:0]);
    check("overrun flag", ovr, 1);
    sbr = 1'b1;
    tick(40);
    check("oldest byte", rx_q[0], 8'h10);
    check("buffer depth", rx_q.size() >= 8, 1);
    close_out();
  end
endmodule // layer3_decoder_io_and_clocks_tb
